/* cps_pkg.sv */
// Package with constants, field layouts and carrier types for the course program sequencer
package cps_pkg;

  // Program size
  localparam int STEPS = 32;
  localparam int LINE_W = 5;
  localparam int POS_W = 6;
  localparam int DIN_W = 8;

  // Timing: one program evaluation tick
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1600000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;

  // Register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_START_A = 8'h04;
  localparam logic [7:0] OFS_START_B = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_STEP_BASE = 8'h80;

  // Control register fields and reset value
  localparam int CTRL_ALT_MAP = 0;
  localparam int CTRL_POS64 = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0002;

  // Status register fields
  localparam int STAT_LINE_LSB = 0;
  localparam int STAT_POS_LSB = 8;
  localparam int STAT_ACTIVE = 16;
  localparam int STAT_MOVING = 17;
  localparam int STAT_HALT = 18;
  localparam int STAT_DONE = 19;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Input pin positions, standard map
  localparam int STD_BR_B = 0, STD_BR_A = 1, STD_STOP = 2, STD_MODE = 3;
  localparam int STD_ENT_A = 4, STD_ENT_B = 5, STD_GO = 6, PIN_JUMP = 7;
  // Input pin positions, alternative map
  localparam int ALT_MODE = 0, ALT_STOP = 1, ALT_BR_B = 2, ALT_ENT_B = 3;
  localparam int ALT_BR_A = 4, ALT_ENT_A = 5, ALT_GO = 6;
  // Destination select and group select pins in normal positioning
  localparam int SEL_LSB = 0;
  localparam int GRP_LSB = 4;

  // Output setting per step
  typedef enum logic [1:0] {
    OUT_OFF = 2'h0,
    OUT_ON = 2'h1,
    OUT_REACHED = 2'h2,
    OUT_REMAIN = 2'h3
  } cps_outmode_t;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_MOVE = 4'b0010,
    ST_DWELL = 4'b0100,
    ST_DONE = 4'b1000
  } cps_state_t;

  // One program step, also its register word layout
  typedef struct packed {
    logic last;
    logic [2:0] rsv3;
    cps_outmode_t out_b;
    cps_outmode_t out_a;
    logic [2:0] rsv2;
    logic [LINE_W-1:0] next_b;
    logic [2:0] rsv1;
    logic [LINE_W-1:0] next_a;
    logic [1:0] rsv0;
    logic [POS_W-1:0] pos;
  } cps_step_t;

  // Input functions after pin mapping
  typedef struct packed {
    logic mode_sel;
    logic stop_n;
    logic br_a;
    logic br_b;
    logic ent_a;
    logic ent_b;
    logic go;
    logic jump;
  } cps_pins_t;

  // AXI4-Lite request and answer bundles
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } cps_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cps_axi_rsp_t;

endpackage

/* cps_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module cps_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Asynchronous inputs and filtered result
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  import cps_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] filt;
  } cps_sync_t;

  cps_sync_t s;
  cps_sync_t n;

  always_comb begin
    n = s;
    n.s1 = d;
    n.s2 = s.s1;
    n.s3 = s.s2;
    for (int i = 0; i < W; i++) begin
      // A change counts once the second and third stages agree
      if (s.s2[i] == s.s3[i]) begin
        n.filt[i] = s.s3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign q = s.filt;

endmodule

/* cps_seq.sv */
// Course program sequencer with AXI4-Lite register access
`timescale 1ns/1ps
// Function
// - Program holds up to 32 steps, each naming a target position.
// - Each step has two successors chosen by the branch-select inputs.
// - Successors may point back to earlier steps, forming loops.
// - Each step sets both outputs: on, off, target reached, or remaining distance.
// - Lines evaluate once per 1.6 ms tick; outputs hold at least a tick.
// - Rising entry-point edge moves to its start line and runs from there.
// - Entry point A wins over B when both edges share one tick.
// - Branch edge A takes successor A, B takes B; A wins ties.
// - Stop low halts the running move and keeps the current line.
// - Mode high runs the program; low finishes the move then normal positioning.
// - Start-input edge starts positioning with mode low, homing with mode high.
// - Standard pin map of the seven control inputs.
// - Alternative pin map selected by a configuration bit.
// - Inactive sequencer offers half the destinations: 32 or 8.
// - Standard map: four groups of eight, or positions 0 to 7.
// - Alternative map: only even positions reachable.
// - Dedicated input jumps to an input-selected position out of order.
// - Stop release resumes; branch edges still latch; outputs unaffected by stop.
// - Forced settings apply at once; reached/remaining only after the move starts.
module cps_seq #(
  parameter int TICK_CYCLES = cps_pkg::TICK_CYC
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Register bus
  input wire cps_pkg::cps_axi_req_t AXI_REQ,
  output cps_pkg::cps_axi_rsp_t AXI_RSP,
  // Digital inputs from the outside controller
  input wire logic [cps_pkg::DIN_W-1:0] DIN,
  // Status from the motion core
  input wire logic TARGET_REACHED,
  input wire logic REMAIN_MSG,
  // Commands to the motion core
  output logic MOVE_START,
  output logic MOVE_HOME,
  output logic MOVE_HALT,
  output logic [cps_pkg::POS_W-1:0] MOVE_POS,
  // Sequencer outputs
  output logic SEQ_OUTPUT_A,
  output logic SEQ_OUTPUT_B
);
  import cps_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES);

  if (TICK_CYCLES < 2) begin : g_chk
    $error("TICK_CYCLES must be at least 2");
  end

  typedef struct packed {
    cps_step_t [STEPS-1:0] prog;
    logic alt_map;
    logic pos64;
    logic [LINE_W-1:0] start_a;
    logic [LINE_W-1:0] start_b;
    logic [TW-1:0] tick_cnt;
    logic [DIN_W-1:0] din_prev;
    logic lat_ent_a;
    logic lat_ent_b;
    logic lat_br_a;
    logic lat_br_b;
    logic lat_go;
    logic lat_jump;
    cps_state_t fsm;
    logic [LINE_W-1:0] line;
    logic [POS_W-1:0] pos;
    logic moving;
    logic halt;
    logic start_p;
    logic home_p;
    logic out_a;
    logic out_b;
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    cps_axi_rsp_t rsp;
  } cps_core_t;

  cps_core_t s;
  cps_core_t n;
  logic [DIN_W-1:0] filt;
  cps_pins_t pin;
  cps_pins_t pin_prev;
  logic tick;
  logic act;

  // Maps raw pins to functions under either pin map
  function automatic cps_pins_t map_pins(input logic alt, input logic [DIN_W-1:0] d);
    cps_pins_t p;
    p.jump = d[PIN_JUMP];
    if (alt) begin
      p.mode_sel = d[ALT_MODE];
      p.stop_n = d[ALT_STOP];
      p.br_b = d[ALT_BR_B];
      p.ent_b = d[ALT_ENT_B];
      p.br_a = d[ALT_BR_A];
      p.ent_a = d[ALT_ENT_A];
      p.go = d[ALT_GO];
    end else begin
      p.br_b = d[STD_BR_B];
      p.br_a = d[STD_BR_A];
      p.stop_n = d[STD_STOP];
      p.mode_sel = d[STD_MODE];
      p.ent_a = d[STD_ENT_A];
      p.ent_b = d[STD_ENT_B];
      p.go = d[STD_GO];
    end
    return p;
  endfunction

  // Input-selected destination with halved range
  function automatic logic [POS_W-1:0] sel_pos(input logic alt, input logic p64, input logic [DIN_W-1:0] d);
    logic [2:0] sel;
    logic [1:0] grp;
    sel = d[SEL_LSB +: 3];
    grp = d[GRP_LSB +: 2];
    if (alt) begin
      sel_pos = p64 ? {grp, sel, 1'b0} : {2'b00, sel, 1'b0};
    end else begin
      sel_pos = p64 ? {grp, 1'b0, sel} : {3'b000, sel};
    end
  endfunction

  // Next output level from the step setting
  function automatic logic out_val(input cps_outmode_t m, input logic cur, input logic fresh,
                                   input logic run, input logic reached, input logic remain);
    out_val = cur;
    case (m)
      OUT_ON: out_val = (fresh || run) ? 1'b1 : cur;
      OUT_OFF: out_val = (fresh || run) ? 1'b0 : cur;
      OUT_REACHED: out_val = run ? reached : cur;
      OUT_REMAIN: out_val = run ? remain : cur;
      default: out_val = cur;
    endcase
  endfunction

  // Register read decode: error flag and data
  function automatic logic [32:0] reg_rd(input cps_core_t c, input logic [ADDR_W-1:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a >= OFS_STEP_BASE) begin
      return {1'b0, c.prog[a[2 +: LINE_W]]};
    end
    case ({a[ADDR_W-1:2], 2'b00})
      OFS_CTRL: begin
        v[CTRL_ALT_MAP] = c.alt_map;
        v[CTRL_POS64] = c.pos64;
      end
      OFS_START_A: v[LINE_W-1:0] = c.start_a;
      OFS_START_B: v[LINE_W-1:0] = c.start_b;
      OFS_STATUS: begin
        v[STAT_LINE_LSB +: LINE_W] = c.line;
        v[STAT_POS_LSB +: POS_W] = c.pos;
        v[STAT_ACTIVE] = act;
        v[STAT_MOVING] = c.moving;
        v[STAT_HALT] = c.halt;
        v[STAT_DONE] = (c.fsm == ST_DONE);
      end
      default: return {1'b1, 32'h0000_0000};
    endcase
    return {1'b0, v};
  endfunction

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = st[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  cps_sync #(
    .W(DIN_W)
  ) u_sync (
    .clk(MCLK),
    .rst(RST),
    .d(DIN),
    .q(filt)
  );

  assign pin = map_pins(s.alt_map, filt);
  assign pin_prev = map_pins(s.alt_map, s.din_prev);
  assign tick = (s.tick_cnt == TW'(TICK_CYCLES - 1));
  assign act = pin.mode_sel;

  always_comb begin
    logic do_ent;
    logic [LINE_W-1:0] ent_line;
    logic run;
    cps_step_t st;
    logic [32:0] rd;
    logic [31:0] wv;
    do_ent = 1'b0;
    ent_line = s.line;
    run = 1'b0;
    st = s.prog[s.line];
    rd = 33'h0_0000_0000;
    wv = 32'h0000_0000;
    n = s;
    n.start_p = 1'b0;
    n.home_p = 1'b0;
    n.din_prev = filt;
    n.tick_cnt = tick ? '0 : s.tick_cnt + TW'(1);
    if (tick) begin
      n.lat_ent_a = 1'b0;
      n.lat_ent_b = 1'b0;
      n.lat_go = 1'b0;
      n.lat_jump = 1'b0;
      n.halt = act && s.moving && !pin.stop_n;
      if (s.moving && TARGET_REACHED && !s.halt) begin
        n.moving = 1'b0;
      end
      if (!act) begin
        n.lat_br_a = 1'b0;
        n.lat_br_b = 1'b0;
        if (!s.moving) begin
          n.fsm = ST_IDLE;
          if (s.lat_go) begin
            n.pos = sel_pos(s.alt_map, s.pos64, filt);
            n.start_p = 1'b1;
            n.moving = 1'b1;
          end
        end
      end else begin
        if (s.lat_go) begin
          n.home_p = 1'b1;
        end
        if (s.lat_ent_a) begin
          do_ent = 1'b1;
          ent_line = s.start_a;
        end else if (s.lat_ent_b) begin
          do_ent = 1'b1;
          ent_line = s.start_b;
        end else if (s.lat_jump && !s.moving) begin
          n.pos = sel_pos(s.alt_map, s.pos64, filt);
          n.start_p = 1'b1;
          n.moving = 1'b1;
          n.fsm = ST_MOVE;
        end else begin
          case (s.fsm)
            ST_MOVE: begin
              if (!s.moving) begin
                n.fsm = ST_DWELL;
              end
            end
            ST_DWELL: begin
              if (pin.stop_n) begin
                if (st.last) begin
                  n.fsm = ST_DONE;
                end else if (s.lat_br_a) begin
                  do_ent = 1'b1;
                  ent_line = st.next_a;
                end else if (s.lat_br_b) begin
                  do_ent = 1'b1;
                  ent_line = st.next_b;
                end
              end
            end
            default: ;
          endcase
        end
        run = (s.fsm == ST_MOVE || s.fsm == ST_DWELL) && !do_ent;
      end
      if (do_ent) begin
        st = s.prog[ent_line];
        n.line = ent_line;
        n.pos = st.pos;
        n.start_p = 1'b1;
        n.moving = 1'b1;
        n.fsm = ST_MOVE;
        n.lat_br_a = 1'b0;
        n.lat_br_b = 1'b0;
      end
      // Outputs ignore the stop level
      n.out_a = out_val(st.out_a, s.out_a, do_ent, run, TARGET_REACHED, REMAIN_MSG);
      n.out_b = out_val(st.out_b, s.out_b, do_ent, run, TARGET_REACHED, REMAIN_MSG);
    end
    // Edge latches set after consumption so a new edge wins
    if (pin.ent_a && !pin_prev.ent_a) n.lat_ent_a = 1'b1;
    if (pin.ent_b && !pin_prev.ent_b) n.lat_ent_b = 1'b1;
    if (pin.br_a && !pin_prev.br_a) n.lat_br_a = 1'b1;
    if (pin.br_b && !pin_prev.br_b) n.lat_br_b = 1'b1;
    if (pin.go && !pin_prev.go) n.lat_go = 1'b1;
    if (pin.jump && !pin_prev.jump) n.lat_jump = 1'b1;

    // Bus write side
    if (AXI_REQ.awvalid && s.rsp.awready) begin
      n.aw_held = 1'b1;
      n.awaddr = AXI_REQ.awaddr;
    end
    if (AXI_REQ.wvalid && s.rsp.wready) begin
      n.w_held = 1'b1;
      n.wdata = AXI_REQ.wdata;
      n.wstrb = AXI_REQ.wstrb;
    end
    if (s.rsp.bvalid && AXI_REQ.bready) begin
      n.rsp.bvalid = 1'b0;
    end
    if (s.aw_held && s.w_held && !s.rsp.bvalid) begin
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.rsp.bvalid = 1'b1;
      n.rsp.bresp = RESP_OKAY;
      rd = reg_rd(s, s.awaddr);
      wv = merge(rd[31:0], s.wdata, s.wstrb);
      if (s.awaddr >= OFS_STEP_BASE) begin
        n.prog[s.awaddr[2 +: LINE_W]] = cps_step_t'(wv);
        n.prog[s.awaddr[2 +: LINE_W]].rsv0 = '0;
        n.prog[s.awaddr[2 +: LINE_W]].rsv1 = '0;
        n.prog[s.awaddr[2 +: LINE_W]].rsv2 = '0;
        n.prog[s.awaddr[2 +: LINE_W]].rsv3 = '0;
      end else begin
        case ({s.awaddr[ADDR_W-1:2], 2'b00})
          OFS_CTRL: begin
            n.alt_map = wv[CTRL_ALT_MAP];
            n.pos64 = wv[CTRL_POS64];
          end
          OFS_START_A: n.start_a = wv[LINE_W-1:0];
          OFS_START_B: n.start_b = wv[LINE_W-1:0];
          OFS_STATUS: ;
          default: n.rsp.bresp = RESP_SLVERR;
        endcase
      end
    end
    n.rsp.awready = !n.aw_held && !n.rsp.bvalid;
    n.rsp.wready = !n.w_held && !n.rsp.bvalid;

    // Bus read side
    if (s.rsp.rvalid && AXI_REQ.rready) begin
      n.rsp.rvalid = 1'b0;
    end
    if (AXI_REQ.arvalid && s.rsp.arready) begin
      rd = reg_rd(s, AXI_REQ.araddr);
      n.rsp.rvalid = 1'b1;
      n.rsp.rdata = rd[31:0];
      n.rsp.rresp = rd[32] ? RESP_SLVERR : RESP_OKAY;
    end
    n.rsp.arready = !n.rsp.rvalid;
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      s <= '0;
      s.fsm <= ST_IDLE;
      s.alt_map <= CTRL_RESET[CTRL_ALT_MAP];
      s.pos64 <= CTRL_RESET[CTRL_POS64];
      s.rsp.awready <= 1'b1;
      s.rsp.wready <= 1'b1;
      s.rsp.arready <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign AXI_RSP = s.rsp;
  assign MOVE_START = s.start_p;
  assign MOVE_HOME = s.home_p;
  assign MOVE_HALT = s.halt;
  assign MOVE_POS = s.pos;
  assign SEQ_OUTPUT_A = s.out_a;
  assign SEQ_OUTPUT_B = s.out_b;

  // Checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  logic [LINE_W-1:0] nxt_a;
  logic [LINE_W-1:0] nxt_b;
  assign nxt_a = s.prog[s.line].next_a;
  assign nxt_b = s.prog[s.line].next_b;

  property p_out_on_tick;
    !$stable(SEQ_OUTPUT_A) || !$stable(SEQ_OUTPUT_B) |-> $past(tick);
  endproperty
  a_out_on_tick: assert property (p_out_on_tick) else $error("output changed off tick");

  property p_entry_a;
    tick && act && s.lat_ent_a |=> MOVE_START && s.line == $past(s.start_a) && s.fsm == ST_MOVE;
  endproperty
  a_entry_a: assert property (p_entry_a) else $error("entry A not taken");

  property p_entry_b;
    tick && act && !s.lat_ent_a && s.lat_ent_b |=> MOVE_START && s.line == $past(s.start_b);
  endproperty
  a_entry_b: assert property (p_entry_b) else $error("entry B not taken");

  property p_branch;
    tick && act && pin.stop_n && s.fsm == ST_DWELL && !s.lat_ent_a && !s.lat_ent_b && !s.lat_jump
      && !s.prog[s.line].last && (s.lat_br_a || s.lat_br_b)
      |=> s.line == ($past(s.lat_br_a) ? $past(nxt_a) : $past(nxt_b)) && MOVE_START;
  endproperty
  a_branch: assert property (p_branch) else $error("wrong successor");

  property p_halt;
    tick && act && s.moving && !pin.stop_n |=> MOVE_HALT ##1 MOVE_HALT [*2];
  endproperty
  a_halt: assert property (p_halt) else $error("stop did not halt move");

  property p_stay;
    tick && s.fsm == ST_DWELL && !pin.stop_n && !s.lat_ent_a && !s.lat_ent_b |=> s.line == $past(s.line);
  endproperty
  a_stay: assert property (p_stay) else $error("line left during stop");

  property p_latch;
    !tick && pin.ent_a && !pin_prev.ent_a |=> s.lat_ent_a;
  endproperty
  a_latch: assert property (p_latch) else $error("entry edge lost");

  property p_no_new_move;
    tick && !act && s.moving |=> !MOVE_START && !MOVE_HOME;
  endproperty
  a_no_new_move: assert property (p_no_new_move) else $error("move started before finish");

  property p_home;
    tick && act && s.lat_go |=> MOVE_HOME ##1 !MOVE_HOME;
  endproperty
  a_home: assert property (p_home) else $error("homing not started");

  property p_bresp;
    s.aw_held && s.w_held && !s.rsp.bvalid |=> AXI_RSP.bvalid;
  endproperty
  a_bresp: assert property (p_bresp) else $error("write not answered");

endmodule

/* cps_partner.sv */
// Outside controller and motion feedback model for the sequencer bench
`timescale 1ns/1ps
module cps_partner (
  // Clock
  input wire logic clk,
  // Motion command seen
  input wire logic move_start,
  // Pins and motion status driven
  output logic [7:0] din,
  output logic reached,
  output logic remain
);
  logic [7:0] base = 8'h04;
  logic [7:0] edg = 8'h00;
  int dly = 8;
  int cnt = 0;
  assign din = base | edg;
  // Levels are held for several ticks by the caller
  task automatic lvl(input logic [7:0] v);
    @(posedge clk);
    base <= v;
  endtask
  // Edge inputs held high for three ticks
  task automatic pulse(input logic [7:0] m);
    @(posedge clk);
    edg <= m;
    repeat (60) @(posedge clk);
    edg <= 8'h00;
  endtask
  // At target until a move starts, then again after dly cycles
  always @(posedge clk) begin
    if (move_start) begin
      cnt <= dly;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  assign reached = (cnt == 0);
  assign remain = (cnt < 4);
endmodule

/* course_program_sequencer_bench.sv */
// Self-checking bench for the course program sequencer
`timescale 1ns/1ps
module course_program_sequencer_bench;
  import cps_pkg::*;
  localparam int TK = 20;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  cps_axi_req_t req = '0;
  cps_axi_rsp_t rsp;
  logic [7:0] din;
  logic reached, remain, mv_start, mv_home, mv_halt, out_a, out_b;
  logic [5:0] mv_pos;
  logic [33:0] q_rd[$];
  logic [1:0] q_b[$];
  logic [7:0] q_mv[$];
  int num_errors = 0;
  int total_checks = 0;
  logic [5:0] p[3];
  logic [31:0] w;
  logic [2:0] s;
  always #5 mclk = ~mclk;
  cps_seq #(.TICK_CYCLES(TK)) uut (.MCLK(mclk), .RST(rst), .AXI_REQ(req), .AXI_RSP(rsp), .DIN(din),
    .TARGET_REACHED(reached), .REMAIN_MSG(remain), .MOVE_START(mv_start), .MOVE_HOME(mv_home),
    .MOVE_HALT(mv_halt), .MOVE_POS(mv_pos), .SEQ_OUTPUT_A(out_a), .SEQ_OUTPUT_B(out_b));
  cps_partner partner (.clk(mclk), .move_start(mv_start), .din(din), .reached(reached), .remain(remain));
  task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic timeout();
    num_errors++;
    $display("[FAIL] wait expected done seen timeout");
    final_report();
  endtask
  // Monitor: each result takes the oldest note of its kind
  always @(posedge mclk) begin
    if (!rst) begin
      if (rsp.rvalid && req.rready) begin
        check("read", {rsp.rresp, rsp.rdata}, q_rd.size() ? q_rd.pop_front() : 'x);
      end
      if (rsp.bvalid && req.bready) begin
        check("bresp", rsp.bresp, q_b.size() ? q_b.pop_front() : 'x);
      end
      if (mv_start || mv_home) begin
        check("move", {mv_home, mv_start, mv_start ? mv_pos : 6'h00}, q_mv.size() ? q_mv.pop_front() : 'x);
      end
    end
  end
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    q_b.push_back(er);
    @(posedge mclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge mclk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    req.bready <= 1'b0;
    if (i == 100) timeout();
  endtask
  task automatic axr(input logic [7:0] a, input logic [33:0] e);
    int i;
    q_rd.push_back(e);
    @(posedge mclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge mclk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    req.rready <= 1'b0;
    if (i == 100) timeout();
  endtask
  task automatic wait_mv();
    int i;
    for (i = 0; i < 400 && q_mv.size() > 0; i++) @(posedge mclk);
    if (q_mv.size() > 0) timeout();
  endtask
  // Expect one move, send an edge, wait for the move
  task automatic step(input logic [7:0] e, input logic [7:0] m);
    repeat (5 * TK) @(posedge mclk);
    q_mv.push_back(e);
    partner.pulse(m);
    wait_mv();
  endtask
  initial begin
    void'($urandom(32'h20C0978F));
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    axr(OFS_CTRL, {RESP_OKAY, CTRL_RESET});
    axr(OFS_START_A, {RESP_OKAY, 32'h0});
    axr(8'h40, {RESP_SLVERR, 32'h0});
    axw(8'h40, 32'h1, RESP_SLVERR);
    axw(OFS_STATUS, 32'hFFFFFFFF, RESP_OKAY);
    $display("Test registers done");
    foreach (p[k]) p[k] = 6'($urandom);
    // Step 1 loops back to step 0; step 2 ends the program
    for (int k = 0; k < 3; k++) begin
      w = (k == 0) ? 32'h0102_0100 : (k == 1) ? 32'h0402_0000 : 32'h8E00_0000;
      w[5:0] = p[k];
      axw(OFS_STEP_BASE + 8'(4 * k), w | 32'h4000_00C0, RESP_OKAY);
      axr(OFS_STEP_BASE + 8'(4 * k), {RESP_OKAY, w});
    end
    w = $urandom;
    axw(8'hFC, w, RESP_OKAY);
    axr(8'hFC, {RESP_OKAY, w & 32'h8F1F_1F3F});
    axw(OFS_START_B, 32'h2, RESP_OKAY);
    axr(OFS_START_B, {RESP_OKAY, 32'h2});
    $display("Test program done");
    partner.dly = 5 + ($urandom % 20);
    partner.lvl(8'h0C);
    step({2'b01, p[0]}, 8'h30);
    repeat (2 * TK) @(posedge mclk);
    check("outputs", {out_a, out_b}, 2'b10);
    step({2'b01, p[1]}, 8'h03);
    repeat (2 * TK) @(posedge mclk);
    check("outputs", {out_a, out_b}, 2'b01);
    step({2'b01, p[0]}, 8'h02);
    $display("Test branches done");
    partner.dly = 300;
    step({2'b01, p[2]}, 8'h20);
    partner.lvl(8'h08);
    repeat (3 * TK) @(posedge mclk);
    check("halt", mv_halt, 1'b1);
    check("outputs", {out_a, out_b}, 2'b00);
    partner.lvl(8'h0C);
    repeat (3 * TK) @(posedge mclk);
    check("halt", mv_halt, 1'b0);
    $display("Test stop done");
    repeat (10 * TK) @(posedge mclk);
    check("outputs", {out_a, out_b}, 2'b11);
    step({2'b10, 6'h00}, 8'h40);
    partner.dly = 5;
    step({2'b01, 6'h04}, 8'h80);
    s = 3'($urandom);
    partner.lvl({5'h00, s});
    step({2'b01, 3'h0, s}, 8'h40);
    $display("Test normal positioning done");
    axw(OFS_CTRL, 32'h1, RESP_OKAY);
    axr(OFS_CTRL, {RESP_OKAY, 32'h1});
    partner.lvl({5'h00, s[2:1], 1'b0});
    step({2'b01, 2'h0, s[2:1], 2'h0}, 8'h40);
    $display("Test alternative map done");
    final_report();
  end
endmodule
